// >>> hw/pcac_pkg.sv
// Package: register map, field positions and carriers of the counter array
package pcac_pkg;
  // ****************************************
  // Register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_CTRL = 8'hd8;
  localparam logic [7:0] IDX_AMODE = 8'hd9;
  localparam logic [7:0] IDX_MMODE0 = 8'hda;
  localparam logic [7:0] IDX_GATE = 8'hdf;
  localparam logic [7:0] IDX_CNT_L = 8'he9;
  localparam logic [7:0] IDX_CAP_L0 = 8'hea;
  localparam logic [7:0] IDX_CNT_H = 8'hf9;
  localparam logic [7:0] IDX_CAP_H0 = 8'hfa;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_RUN_BIT = 6;
  localparam int AMODE_OVF_IE_BIT = 0;
  localparam int AMODE_CPS_LSB = 1;
  localparam int AMODE_WDT_EN_BIT = 6;
  localparam int GATE_BIT = 0;
  localparam int WDT_MODULE = 4;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] AMODE_RST = 8'h00;
  localparam logic [7:0] MMODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CAP_RST = 16'h0000;
  localparam logic GATE_RST = 1'b0;
  // ****************************************
  // Count source choices
  // ****************************************
  localparam logic [1:0] CPS_SYS = 2'h0;
  localparam logic [1:0] CPS_SYS_HALF = 2'h1;
  localparam logic [1:0] CPS_TMR_OVF = 2'h2;
  localparam logic [1:0] CPS_EXT = 2'h3;

  typedef struct packed {
    logic rsvd;
    logic cmp_en;
    logic rise_cap;
    logic fall_cap;
    logic flag_hit;
    logic flip_hit;
    logic pwm;
    logic irq_en;
  } pcac_mmode_s;

  typedef struct packed {
    logic wdt_en;
    logic [1:0] src;
    logic ovf_ie;
  } pcac_amode_s;
endpackage : pcac_pkg

// >>> hw/pcac_core.sv
// Counter array: 16-bit counter, five compare/capture modules, Wishbone slave
//
// Notes on behaviour
// - Run bit set by software starts the counter; clearing it stops it.
// - While running the counter advances at the selected count source rate.
// - Overflow flag, control bit 7, sets when counter wraps ffff to 0000.
// - Overflow request only when flag, overflow enable and global gate set.
// - Hardware never clears overflow flag; software writes zero to clear.
// - Control bits 0..4 are module flags, set on match or capture.
// - Module flags are cleared only by software writes.
// - Module request only when flag, module enable bit 0 and gate set.
// - Counter is 16 bits, low and high byte registers, reset to zero.
// - Five modules: capture, software timer, high speed output, 8-bit PWM.
// - Only module 4 can also act as watchdog.
// - Mode bit 1 selects PWM, driving the module pin as PWM output.
// - Mode bit 2 inverts the module pin on each compare match.
// - Mode bit 3 sets the module flag on each compare match.
// - Mode bit 4 captures on falling edges, bit 5 on rising edges.
// - Both capture bits set capture on every input transition.
// - Mode bit 6 enables comparison of counter against compare register.
// - A capture copies the 16-bit counter into the module capture registers.
// - Match flagging needs both flag bit and comparator; else no flag.
`timescale 1ns/10ps
module pcac_core #(
  parameter int NUM_MOD = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Count sources
  input wire logic tmr_ovf_pulse,
  input wire logic ext_count_in,
  // Module pins, split three ways
  input wire logic [NUM_MOD-1:0] module_io_pin_i,
  output logic [NUM_MOD-1:0] module_io_pin_o,
  output logic [NUM_MOD-1:0] module_io_pin_oe,
  // Requests and watchdog
  output logic overflow_irq,
  output logic [NUM_MOD-1:0] module_irq,
  output logic wdt_reset
);
  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic [NUM_MOD:0] mod_hit(input logic [7:0] idx, input logic [7:0] base);
    logic [NUM_MOD:0] r;
    r = '0;
    for (int i = 0; i < NUM_MOD; i++) begin
      if (idx == base + 8'(i)) begin
        r = {1'b1, NUM_MOD'(1 << i)};
      end
    end
    return r;
  endfunction : mod_hit

  logic [7:0] idx;
  logic req;
  logic wr;
  logic [7:0] wdat;
  logic [NUM_MOD:0] hit_mm;
  logic [NUM_MOD:0] hit_cl;
  logic [NUM_MOD:0] hit_ch;
  logic ack_q;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];
  assign hit_mm = mod_hit(idx, pcac_pkg::IDX_MMODE0);
  assign hit_cl = mod_hit(idx, pcac_pkg::IDX_CAP_L0);
  assign hit_ch = mod_hit(idx, pcac_pkg::IDX_CAP_H0);

  // ****************************************
  // Write strobes, one per register
  // ****************************************
  // Strobes fire once per transfer, at the edge that raises ack
  logic wr_ctrl;
  logic wr_amode;
  logic wr_gate;
  logic wr_cnt_l;
  logic wr_cnt_h;
  logic wr_cnt;

  assign wr_ctrl = wr && idx == pcac_pkg::IDX_CTRL;
  assign wr_amode = wr && idx == pcac_pkg::IDX_AMODE;
  assign wr_gate = wr && idx == pcac_pkg::IDX_GATE;
  assign wr_cnt_l = wr && idx == pcac_pkg::IDX_CNT_L;
  assign wr_cnt_h = wr && idx == pcac_pkg::IDX_CNT_H;
  assign wr_cnt = wr_cnt_l || wr_cnt_h;

  // ****************************************
  // Configuration registers
  // ****************************************
  logic run_q;
  logic ovf_flag_q;
  logic [NUM_MOD-1:0] evt_flag_q;
  logic [NUM_MOD-1:0] evt_set;
  logic gate_q;
  pcac_pkg::pcac_amode_s amode_q;
  pcac_pkg::pcac_mmode_s mmode_q [NUM_MOD];
  logic [15:0] cap_q [NUM_MOD];
  logic [15:0] cnt_q;
  logic tick;
  logic wrap;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= pcac_pkg::CTRL_RST[pcac_pkg::CTRL_RUN_BIT];
    end else if (wr_ctrl) begin
      run_q <= wdat[pcac_pkg::CTRL_RUN_BIT];
    end
  end

  // Hardware set wins over a software write in the same cycle, so no event is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_q <= pcac_pkg::CTRL_RST[pcac_pkg::CTRL_OVF_BIT];
    end else if (wr_ctrl) begin
      ovf_flag_q <= wdat[pcac_pkg::CTRL_OVF_BIT] | wrap;
    end else begin
      ovf_flag_q <= ovf_flag_q | wrap;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      evt_flag_q <= pcac_pkg::CTRL_RST[NUM_MOD-1:0];
    end else if (wr_ctrl) begin
      evt_flag_q <= wdat[NUM_MOD-1:0] | evt_set;
    end else begin
      evt_flag_q <= evt_flag_q | evt_set;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      amode_q.ovf_ie <= pcac_pkg::AMODE_RST[pcac_pkg::AMODE_OVF_IE_BIT];
      amode_q.src <= pcac_pkg::AMODE_RST[pcac_pkg::AMODE_CPS_LSB +: 2];
      amode_q.wdt_en <= pcac_pkg::AMODE_RST[pcac_pkg::AMODE_WDT_EN_BIT];
    end else if (wr_amode) begin
      amode_q.ovf_ie <= wdat[pcac_pkg::AMODE_OVF_IE_BIT];
      amode_q.src <= wdat[pcac_pkg::AMODE_CPS_LSB +: 2];
      amode_q.wdt_en <= wdat[pcac_pkg::AMODE_WDT_EN_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= pcac_pkg::GATE_RST;
    end else if (wr_gate) begin
      gate_q <= wdat[pcac_pkg::GATE_BIT];
    end
  end

  // ****************************************
  // Count pulse selection
  // ****************************************
  logic half_q;
  logic ext_q;

  // Free-running divide by two; its phase against run is not fixed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  // Last level of the external input, for rising-edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_count_in;
    end
  end

  always_comb begin
    case (amode_q.src)
      pcac_pkg::CPS_SYS: tick = run_q;
      pcac_pkg::CPS_SYS_HALF: tick = run_q && half_q;
      pcac_pkg::CPS_TMR_OVF: tick = run_q && tmr_ovf_pulse;
      pcac_pkg::CPS_EXT: tick = run_q && ext_count_in && !ext_q;
      default: tick = 1'b0;
    endcase
  end

  // A byte write in the same cycle wins over the pulse, so no wrap happens then
  assign wrap = tick && cnt_q == 16'hffff && !wr_cnt;

  // ****************************************
  // Counter
  // ****************************************
  // Software byte writes take priority over a pulse in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= pcac_pkg::CNT_RST;
    end else if (wr_cnt_l) begin
      cnt_q[7:0] <= wdat;
    end else if (wr_cnt_h) begin
      cnt_q[15:8] <= wdat;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // Compare only once per counter value, in the cycle after a count pulse; a software byte write does not trigger it
  logic fresh_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fresh_q <= 1'b0;
    end else begin
      fresh_q <= tick;
    end
  end

  // ****************************************
  // Compare/capture modules
  // ****************************************
  logic [NUM_MOD-1:0] pin_prev_q;
  logic [NUM_MOD-1:0] wdt_hit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_prev_q <= '0;
    end else begin
      pin_prev_q <= module_io_pin_i;
    end
  end

  for (genvar m = 0; m < NUM_MOD; m++) begin : g_mod
    pcac_pkg::pcac_mmode_s md;
    logic match;
    logic cap_ev;
    logic pwm_lvl;

    assign md = mmode_q[m];
    assign match = md.cmp_en && fresh_q && cnt_q == cap_q[m];
    assign cap_ev = (md.rise_cap && module_io_pin_i[m] && !pin_prev_q[m])
                  || (md.fall_cap && !module_io_pin_i[m] && pin_prev_q[m]);
    assign evt_set[m] = cap_ev || (match && md.flag_hit && !md.pwm);
    // Watchdog exists only on module 4 and needs the global enable
    assign wdt_hit[m] = (m == pcac_pkg::WDT_MODULE) && amode_q.wdt_en
                      && match && md.flag_hit && !md.pwm;
    // PWM duty compares low count byte against low capture byte
    assign pwm_lvl = cnt_q[7:0] >= cap_q[m][7:0];

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        mmode_q[m] <= pcac_pkg::MMODE_RST;
      end else if (wr && hit_mm[m]) begin
        mmode_q[m] <= {1'b0, wdat[6:0]};
      end
    end

    // Capture beats a software write; PWM reloads low from high on byte wrap
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        cap_q[m] <= pcac_pkg::CAP_RST;
      end else if (cap_ev) begin
        cap_q[m] <= cnt_q;
      end else if (wr && hit_cl[m]) begin
        cap_q[m][7:0] <= wdat;
      end else if (wr && hit_ch[m]) begin
        cap_q[m][15:8] <= wdat;
      end else if (md.pwm && tick && cnt_q[7:0] == 8'hff) begin
        cap_q[m][7:0] <= cap_q[m][15:8];
      end
    end

    // Pin is driven only in modes that own it; otherwise it stays an input
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        module_io_pin_oe[m] <= 1'b0;
      end else begin
        module_io_pin_oe[m] <= md.pwm || (md.flip_hit && md.cmp_en);
      end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        module_io_pin_o[m] <= 1'b0;
      end else begin
        if (md.pwm) begin
          module_io_pin_o[m] <= pwm_lvl;
        end else if (match && md.flip_hit) begin
          module_io_pin_o[m] <= ~module_io_pin_o[m];
        end
      end
    end
  end

  // ****************************************
  // Requests
  // ****************************************
  // Requests are levels that follow the flags; clearing the flag drops them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= ovf_flag_q && amode_q.ovf_ie && gate_q;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      module_irq <= '0;
    end else begin
      for (int i = 0; i < NUM_MOD; i++) begin
        module_irq[i] <= evt_flag_q[i] && mmode_q[i].irq_en && gate_q;
      end
    end
  end

  // One-cycle pulse per watchdog match; the reset itself lies outside this block
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wdt_reset <= 1'b0;
    end else begin
      wdt_reset <= |wdt_hit;
    end
  end

  // ****************************************
  // Read path and acknowledge
  // ****************************************
  logic [7:0] rdat;
  always_comb begin
    rdat = 8'h00;
    for (int i = 0; i < NUM_MOD; i++) begin
      if (hit_mm[i]) begin
        rdat = {1'b0, mmode_q[i][6:0]};
      end
      if (hit_cl[i]) begin
        rdat = cap_q[i][7:0];
      end
      if (hit_ch[i]) begin
        rdat = cap_q[i][15:8];
      end
    end
    case (idx)
      pcac_pkg::IDX_CTRL: rdat = {ovf_flag_q, run_q, 1'b0, evt_flag_q};
      pcac_pkg::IDX_AMODE: rdat = {1'b0, amode_q.wdt_en, 3'h0, amode_q.src, amode_q.ovf_ie};
      pcac_pkg::IDX_GATE: rdat = {7'h00, gate_q};
      pcac_pkg::IDX_CNT_L: rdat = cnt_q[7:0];
      pcac_pkg::IDX_CNT_H: rdat = cnt_q[15:8];
      default: rdat = rdat;
    endcase
  end

  // Unmapped indices still acknowledge, reading zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_q <= req;
      if (req) begin
        wb_dat_o <= {24'h000000, rdat};
      end
    end
  end

  assign wb_ack_o = ack_q;
endmodule : pcac_core

// >>> dv/pcac_core_assertions.sv
// Checker: port-level properties of the counter array core
`timescale 1ns/10ps
module pcac_core_chk #(
  parameter int NUM_MOD = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic overflow_irq,
  input wire logic [NUM_MOD-1:0] module_irq,
  input wire logic wdt_reset
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ****
  // Shadow of the enable bits, updated at the acked write
  // ****
  logic gate_q;
  logic ovf_ie_q;
  logic [NUM_MOD-1:0] ie_q;
  wire wr_hit = wb_ack_o && wb_we_i && wb_sel_i[0];
  wire [7:0] idx = wb_adr_i[9:2];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gate_q <= 1'b0;
      ovf_ie_q <= 1'b0;
      ie_q <= '0;
    end else if (wr_hit) begin
      if (idx == pcac_pkg::IDX_GATE) gate_q <= wb_dat_i[0];
      if (idx == pcac_pkg::IDX_AMODE) ovf_ie_q <= wb_dat_i[0];
      for (int n = 0; n < NUM_MOD; n++) begin
        if (idx == pcac_pkg::IDX_MMODE0 + 8'(n)) ie_q[n] <= wb_dat_i[0];
      end
    end
  end
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_single_pulse: assert property (s_req |=> s_ack_pulse)
    else $error("ack missing or longer than one cycle");
  a_ack_has_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_ctrl_bit_five: assert property (wb_ack_o && !wb_we_i && idx == pcac_pkg::IDX_CTRL
    |-> !wb_dat_o[5])
    else $error("unused control bit reads one");
  a_gate_blocks_irq: assert property (!gate_q |-> !overflow_irq && !(|module_irq))
    else $error("request with gate off");
  a_ovf_ie_blocks: assert property (!ovf_ie_q |-> !overflow_irq)
    else $error("overflow request while disabled");
  a_mod_ie_blocks: assert property (!(|(module_irq & ~ie_q)))
    else $error("module request while disabled");
  a_wdt_one_pulse: assert property (wdt_reset |=> !wdt_reset)
    else $error("watchdog pulse too long");
endmodule : pcac_core_chk

bind pcac_core pcac_core_chk #(.NUM_MOD(NUM_MOD)) chk_u (.clk_sys(clk_sys), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .overflow_irq(overflow_irq), .module_irq(module_irq), .wdt_reset(wdt_reset));

// >>> dv/pcac_pin_model.sv
// Far-side model: spaced count pulses and module pin levels
`timescale 1ns/10ps
module pcac_pin_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] burst_len,
  input wire logic [4:0] pin_lvl,
  input wire logic ext_lvl,
  output logic tmr_ovf_pulse,
  output logic ext_count_in,
  output logic [4:0] module_io_pin_i
);
  logic [3:0] left_q;
  // Pulses spaced by an idle cycle so each one is a clean single-cycle event
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 4'h0;
      tmr_ovf_pulse <= 1'b0;
    end else if (burst_len != 4'h0) begin
      left_q <= burst_len;
      tmr_ovf_pulse <= 1'b0;
    end else if (left_q != 4'h0 && !tmr_ovf_pulse) begin
      left_q <= left_q - 4'h1;
      tmr_ovf_pulse <= 1'b1;
    end else begin
      tmr_ovf_pulse <= 1'b0;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) module_io_pin_i <= 5'h00;
    else module_io_pin_i <= pin_lvl;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) ext_count_in <= 1'b0;
    else ext_count_in <= ext_lvl;
  end
endmodule : pcac_pin_model

// >>> dv/pcac_core_tb.sv
// Testbench: registers, counting, overflow, capture, compare and PWM
`timescale 1ns/10ps
module pcac_core_tb;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [3:0] wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h00000000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, tmr_ovf_pulse, ext_count_in, overflow_irq, wdt_reset;
  logic [4:0] pin_i, pin_o, pin_oe, module_irq;
  logic [4:0] pin_lvl = 5'h00;
  logic [3:0] burst_len = 4'h0;
  logic ext_lvl = 1'b0;
  logic [7:0] rd_v;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int wdt_seen = 0;
  always #20 clk_sys = ~clk_sys;
  pcac_core #(.NUM_MOD(5)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .tmr_ovf_pulse(tmr_ovf_pulse), .ext_count_in(ext_count_in), .module_io_pin_i(pin_i),
    .module_io_pin_o(pin_o), .module_io_pin_oe(pin_oe), .overflow_irq(overflow_irq),
    .module_irq(module_irq), .wdt_reset(wdt_reset));
  pcac_pin_model far_u (.clk_sys(clk_sys), .rst_n(rst_n), .burst_len(burst_len),
    .pin_lvl(pin_lvl), .ext_lvl(ext_lvl), .tmr_ovf_pulse(tmr_ovf_pulse),
    .ext_count_in(ext_count_in), .module_io_pin_i(pin_i));
  // ****
  // Shared tasks
  // ****
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h000000, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd_v = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd_v, exp);
  endtask : rd
  task automatic pulses(input logic [3:0] n);
    @(posedge clk_sys);
    burst_len <= n;
    @(posedge clk_sys);
    burst_len <= 4'h0;
    repeat (2 * n + 4) @(posedge clk_sys);
  endtask : pulses
  task automatic pin(input logic [4:0] lvl);
    @(posedge clk_sys);
    pin_lvl <= lvl;
    repeat (5) @(posedge clk_sys);
  endtask : pin
  // ****
  // Scenarios
  // ****
  task automatic t_regs;
    rd(pcac_pkg::IDX_CTRL, 8'h00);
    rd(pcac_pkg::IDX_CNT_L, 8'h00);
    rd(pcac_pkg::IDX_CNT_H, 8'h00);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h20);
    rd(pcac_pkg::IDX_CTRL, 8'h00);
    rd(8'h00, 8'h00);
  endtask : t_regs
  task automatic t_overflow;
    wb(1'b1, pcac_pkg::IDX_GATE, 8'h01);
    wb(1'b1, pcac_pkg::IDX_AMODE, 8'h05);
    wb(1'b1, pcac_pkg::IDX_CNT_L, 8'hff);
    wb(1'b1, pcac_pkg::IDX_CNT_H, 8'hff);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
    pulses(4'h1);
    chk({7'h00, overflow_irq}, 8'h01);
    rd(pcac_pkg::IDX_CTRL, 8'hc0);
    rd(pcac_pkg::IDX_CNT_H, 8'h00);
    pulses(4'h3);
    rd(pcac_pkg::IDX_CNT_L, 8'h03);
    rd(pcac_pkg::IDX_CTRL, 8'hc0);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h00);
    pulses(4'h2);
    chk({7'h00, overflow_irq}, 8'h00);
    rd(pcac_pkg::IDX_CNT_L, 8'h03);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
  endtask : t_overflow
  task automatic t_capture;
    wb(1'b1, pcac_pkg::IDX_MMODE0, 8'h21);
    pin(5'h01);
    chk({3'h0, module_irq}, 8'h01);
    rd(pcac_pkg::IDX_CTRL, 8'h41);
    rd(pcac_pkg::IDX_CAP_L0, 8'h03);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
    pin(5'h00);
    rd(pcac_pkg::IDX_CTRL, 8'h40);
    wb(1'b1, pcac_pkg::IDX_MMODE0, 8'h30);
    pin(5'h01);
    rd(pcac_pkg::IDX_CTRL, 8'h41);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
    pin(5'h00);
    chk({3'h0, module_irq}, 8'h00);
    rd(pcac_pkg::IDX_CTRL, 8'h41);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
  endtask : t_capture
  task automatic t_compare;
    wb(1'b1, pcac_pkg::IDX_CAP_L0 + 8'h01, 8'h05);
    wb(1'b1, pcac_pkg::IDX_CAP_H0 + 8'h01, 8'h00);
    wb(1'b1, pcac_pkg::IDX_MMODE0 + 8'h01, 8'h4c);
    pulses(4'h2);
    rd(pcac_pkg::IDX_CTRL, 8'h42);
    chk({6'h00, pin_oe[1], pin_o[1]}, 8'h03);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
    wb(1'b1, pcac_pkg::IDX_MMODE0 + 8'h01, 8'h44);
    wb(1'b1, pcac_pkg::IDX_CNT_L, 8'h04);
    pulses(4'h1);
    rd(pcac_pkg::IDX_CTRL, 8'h40);
    chk({7'h00, pin_o[1]}, 8'h00);
  endtask : t_compare
  task automatic t_pwm;
    wb(1'b1, pcac_pkg::IDX_CAP_L0 + 8'h02, 8'h80);
    wb(1'b1, pcac_pkg::IDX_CAP_H0 + 8'h02, 8'h80);
    wb(1'b1, pcac_pkg::IDX_MMODE0 + 8'h02, 8'h42);
    repeat (4) @(posedge clk_sys);
    chk({6'h00, pin_oe[2], pin_o[2]}, 8'h02);
    wb(1'b1, pcac_pkg::IDX_CNT_L, 8'h90);
    repeat (2) @(posedge clk_sys);
    chk({6'h00, pin_oe[2], pin_o[2]}, 8'h03);
  endtask : t_pwm
  // Runs from zero for a fixed window; one external rising edge inside it
  task automatic count_run(input logic [7:0] amode, input logic [7:0] exp);
    wb(1'b1, pcac_pkg::IDX_CNT_L, 8'h00);
    wb(1'b1, pcac_pkg::IDX_AMODE, amode);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
    repeat (2) @(posedge clk_sys);
    ext_lvl <= 1'b1;
    repeat (3) @(posedge clk_sys);
    ext_lvl <= 1'b0;
    repeat (2) @(posedge clk_sys);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h00);
    rd(pcac_pkg::IDX_CNT_L, exp);
  endtask : count_run
  task automatic t_sources;
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h00);
    count_run(8'h00, 8'h0a);
    count_run(8'h02, 8'h05);
    count_run(8'h06, 8'h01);
  endtask : t_sources
  task automatic t_wdt;
    wb(1'b1, pcac_pkg::IDX_CAP_L0 + 8'h03, 8'h06);
    wb(1'b1, pcac_pkg::IDX_CAP_L0 + 8'h04, 8'h03);
    wb(1'b1, pcac_pkg::IDX_MMODE0 + 8'h03, 8'h48);
    wb(1'b1, pcac_pkg::IDX_MMODE0 + 8'h04, 8'h48);
    count_run(8'h00, 8'h0a);
    chk(8'(wdt_seen), 8'h00);
    wb(1'b1, pcac_pkg::IDX_AMODE, 8'h40);
    wb(1'b1, pcac_pkg::IDX_CNT_L, 8'h00);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h40);
    repeat (8) @(posedge clk_sys);
    rd(pcac_pkg::IDX_CTRL, 8'h58);
    wb(1'b1, pcac_pkg::IDX_CTRL, 8'h00);
    chk(8'(wdt_seen), 8'h01);
  endtask : t_wdt
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  always @(posedge clk_sys) begin
    if (wdt_reset === 1'b1) wdt_seen++;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs();
    t_overflow();
    t_capture();
    t_compare();
    t_pwm();
    t_sources();
    t_wdt();
    wrap_up();
  end
endmodule : pcac_core_tb
